// ==== core/hpm_header_mux.sv ====
`timescale 1ns/10ps
module hpm_header_mux #(
   parameter int unsigned PULSE_W = 26,
   parameter logic [25:0] PULSE_LEN = 26'(hpm_pkg::PULSE_CYC),
   parameter int unsigned HOLD_W = 31,
   parameter logic [30:0] HOLD_LEN = 31'(hpm_pkg::HOLD_CYC)
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   // pins of the expansion_header (positions 1..13 as bits 0..12)
   input wire logic [12:0] pin_in_i,
   output logic [12:0] pin_out_o,
   output logic [12:0] pin_oe_o,
   // configuration
   input wire logic serial_en_i,
   input wire logic i2c_en_i,
   input wire logic spi_en_i,
   input wire logic atx_en_i,
   input wire logic power_invert_i,
   input wire logic restart_invert_i,
   input wire logic [12:0] gpio_en_i,
   input wire logic [12:0] gpio_dir_out_i,
   input wire logic [12:0] gpio_out_i,
   output logic [12:0] gpio_in_o,
   output logic [1:0] adc_in_o,
   // peripherals
   input wire logic ser_tx_i,
   output logic ser_rx_o,
   input wire logic i2c_sda_oe_i,
   output logic i2c_sda_o,
   output logic i2c_scl_o,
   input wire logic i2c_tx_pending_i,
   input wire logic spi_miso_i,
   output logic spi_mosi_o,
   output logic spi_cs_n_o,
   output logic spi_sck_o,
   input wire logic spi_tx_pending_i,
   // atx actions
   input wire logic power_req_i,
   input wire logic restart_req_i,
   input wire logic watchdog_req_i,
   output logic host_power_on_o,
   output logic atx_busy_o,
   // keypad and boot
   input wire logic key_right_i,
   input wire logic key_cancel_i,
   input wire logic usb_en_i,
   output logic show_revision_o,
   output logic restore_defaults_o,
   output logic usb_active_o,
   output logic serial_active_o
);
   import hpm_pkg::*;

   // header index for each gpio number
   function automatic int unsigned pin_of(input int unsigned g);
      int unsigned p;
      p = 0;
      unique case (g)
         7: p = 0;
         8: p = 1;
         9: p = 2;
         10: p = 3;
         5: p = 4;
         6: p = 5;
         11: p = 6;
         12: p = 7;
         2: p = 8;
         3: p = 9;
         0: p = 10;
         1: p = 11;
         4: p = 12;
         default: p = 0;
      endcase
      return p;
   endfunction : pin_of

   typedef struct packed {
      logic [12:0] pout;
      logic [12:0] poe;
      logic [12:0] gin;
      hpm_pulse_type pst;
      logic [PULSE_W-1:0] pcnt;
      logic busy;
      hpm_boot_type bst;
      logic [HOLD_W-1:0] hcnt;
      logic show;
      logic restore;
      logic usb_act;
      logic ser_act;
   } hpm_state_type;

   hpm_state_type st_reg;
   hpm_state_type st_next;
   logic [12:0] pin_s;
   logic [1:0] keys_s;

   hpm_sync #(.W(13)) u_pin_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .d_i(pin_in_i),
      .q_o(pin_s)
   );
   hpm_sync #(.W(2)) u_key_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .d_i({key_cancel_i, key_right_i}),
      .q_o(keys_s)
   );

   logic host_on;
   logic atx_ok;
   always_comb begin
      host_on = pin_s[pin_of(G_PSNS)]; // R7
      // atx pins usable only when not given to gpio or spi
      atx_ok = atx_en_i && !spi_en_i // R6 R11
               && !gpio_en_i[G_PCTL]
               && !gpio_en_i[G_RCTL];
   end

   always_comb begin
      st_next = st_reg;
      // per-pin role: interface, then gpio, else hi-z
      for (int unsigned g = 0; g < NGPIO; g++) begin // R1 R2
         st_next.pout[pin_of(g)] = gpio_out_i[g];
         st_next.poe[pin_of(g)] = gpio_en_i[g] && gpio_dir_out_i[g];
         st_next.gin[g] = gpio_en_i[g] ? pin_s[pin_of(g)] : 1'b0;
      end
      // analog pins drive only as gpio, and only if the mask enables it as an output
      st_next.poe[pin_of(G_ADC0)] = gpio_en_i[G_ADC0] && gpio_dir_out_i[G_ADC0]; // R3
      if (serial_en_i) begin // R16
         st_next.pout[pin_of(G_STX)] = ser_tx_i;
         st_next.poe[pin_of(G_STX)] = 1'b1;
         st_next.poe[pin_of(G_SRX)] = 1'b0;
         st_next.gin[G_STX] = 1'b0;
         st_next.gin[G_SRX] = 1'b0;
      end
      if (i2c_en_i) begin // R4 R16
         st_next.pout[pin_of(G_SDA)] = 1'b0;
         st_next.poe[pin_of(G_SDA)] = i2c_sda_oe_i;
         st_next.poe[pin_of(G_SCL)] = 1'b0;
         st_next.pout[pin_of(G_I2RDY)] = 1'b0;
         st_next.poe[pin_of(G_I2RDY)] = i2c_tx_pending_i; // R17
         st_next.gin[G_SDA] = 1'b0;
         st_next.gin[G_SCL] = 1'b0;
         st_next.gin[G_I2RDY] = 1'b0;
      end
      if (spi_en_i) begin // R5 R16
         st_next.pout[pin_of(G_MISO)] = spi_miso_i;
         st_next.poe[pin_of(G_MISO)] = 1'b1;
         st_next.poe[pin_of(G_MOSI)] = 1'b0;
         st_next.poe[pin_of(G_PCTL)] = 1'b0;
         st_next.poe[pin_of(G_RCTL)] = 1'b0;
         st_next.pout[pin_of(G_PSNS)] = 1'b0;
         st_next.poe[pin_of(G_PSNS)] = spi_tx_pending_i;
         st_next.gin[G_MISO] = 1'b0;
         st_next.gin[G_MOSI] = 1'b0;
         st_next.gin[G_PCTL] = 1'b0;
         st_next.gin[G_RCTL] = 1'b0;
         st_next.gin[G_PSNS] = 1'b0;
      end

      // atx pulse driver; watchdog shares the restart path
      unique case (st_reg.pst)
         PS_IDLE: begin
            st_next.pcnt = '0;
            if (atx_ok && (restart_req_i || watchdog_req_i)) begin // R9 R10
               st_next.pst = PS_RST;
            end else if (atx_ok && power_req_i) begin // R8
               st_next.pst = PS_PWR;
            end
         end
         PS_PWR, PS_RST: begin
            // count starts at zero on entry, so the pin drives PULSE_LEN edges
            st_next.pcnt = st_reg.pcnt + 1'b1;
            if (st_reg.pcnt == PULSE_LEN - 1'b1) begin // R18
               st_next.pst = PS_IDLE;
            end
         end
         default: st_next.pst = PS_IDLE;
      endcase
      st_next.busy = (st_next.pst != PS_IDLE);
      if (atx_ok) begin
         // idle atx pins high impedance; pulse drives polarity level
         st_next.pout[pin_of(G_PCTL)] = power_invert_i; // R8
         st_next.poe[pin_of(G_PCTL)] = (st_next.pst == PS_PWR);
         st_next.pout[pin_of(G_RCTL)] = restart_invert_i; // R9
         st_next.poe[pin_of(G_RCTL)] = (st_next.pst == PS_RST);
         st_next.poe[pin_of(G_PSNS)] = 1'b0;
      end

      // boot key check after power-on or restart (both release rst_i)
      st_next.restore = st_reg.restore;
      unique case (st_reg.bst)
         BS_CHECK: begin
            // synced keys read as released until both stages have filled
            if (st_reg.hcnt != HOLD_W'(SYNC_STAGES)) begin
               st_next.hcnt = st_reg.hcnt + 1'b1;
            end else if (keys_s == 2'h3) begin // R14
               st_next.restore = 1'b1;
               st_next.bst = BS_DONE;
            end else if (keys_s[0]) begin // R12 R13
               st_next.show = 1'b1;
               st_next.bst = BS_SHOW;
            end else begin
               st_next.bst = BS_DONE;
            end
         end
         BS_SHOW: begin
            // a re-press restarts the linger from a full count
            st_next.hcnt = '0;
            if (!keys_s[0]) begin
               st_next.bst = BS_LINGER;
            end
         end
         BS_LINGER: begin
            st_next.hcnt = st_reg.hcnt + 1'b1;
            if (keys_s[0]) begin
               st_next.bst = BS_SHOW;
            end else if (st_reg.hcnt == HOLD_LEN - 1'b1) begin // R12
               st_next.show = 1'b0;
               st_next.bst = BS_DONE;
            end
         end
         BS_DONE: begin
            st_next.show = 1'b0;
         end
         default: st_next.bst = BS_DONE;
      endcase
      st_next.usb_act = usb_en_i; // R15
      st_next.ser_act = serial_en_i; // R15
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= '{
            pout: '0,
            poe: '0,
            gin: '0,
            pst: PS_IDLE,
            pcnt: '0,
            busy: 1'b0,
            bst: BS_CHECK,
            hcnt: '0,
            show: 1'b0,
            restore: 1'b0,
            usb_act: 1'b0,
            ser_act: 1'b0
         };
      end else begin
         st_reg <= st_next; // R19
      end
   end

   // adc and input-side outputs also registered
   logic [1:0] adc_reg;
   logic [6:1] inp_reg;
   logic pwr_reg;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         adc_reg <= '0;
         // chip select reads inactive while held in reset
         inp_reg <= 6'h02;
         pwr_reg <= 1'b0;
      end else begin
         adc_reg <= {pin_s[pin_of(G_ADC1)], pin_s[pin_of(G_ADC0)]}; // R3
         // inputs read zero with their interface off; select is active low, so it idles high
         inp_reg <= {
            pin_s[pin_of(G_SRX)] & serial_en_i,
            pin_s[pin_of(G_SDA)] & i2c_en_i,
            pin_s[pin_of(G_SCL)] & i2c_en_i,
            pin_s[pin_of(G_MOSI)] & spi_en_i,
            pin_s[pin_of(G_PCTL)] | !spi_en_i,
            pin_s[pin_of(G_RCTL)] & spi_en_i
         };
         pwr_reg <= host_on && atx_ok; // R7
      end
   end

   assign pin_out_o = st_reg.pout;
   assign pin_oe_o = st_reg.poe;
   assign gpio_in_o = st_reg.gin;
   assign adc_in_o = adc_reg;
   assign ser_rx_o = inp_reg[6];
   assign i2c_sda_o = inp_reg[5];
   assign i2c_scl_o = inp_reg[4];
   assign spi_mosi_o = inp_reg[3];
   assign spi_cs_n_o = inp_reg[2];
   assign spi_sck_o = inp_reg[1];
   assign host_power_on_o = pwr_reg;
   assign atx_busy_o = st_reg.busy;
   assign show_revision_o = st_reg.show;
   assign restore_defaults_o = st_reg.restore;
   assign usb_active_o = st_reg.usb_act;
   assign serial_active_o = st_reg.ser_act;
endmodule : hpm_header_mux

// ==== core/hpm_pkg.sv ====
// Function
// (R1) thirteen header pins individually assignable roles
// (R2) role from interface, gpio, atx settings
// (R3) gpio5 and gpio6 default to analog
// (R4) gpio4 pin becomes i2c data ready
// (R5) gpio1 senses power, or spi ready
// (R6) host keeps atx pins default, unshared
// (R7) sensed host power changes behaviour
// (R8) power pin hi-z except polarity pulse
// (R9) reset pin hi-z except polarity pulse
// (R10) watchdog shares the host reset driver
// (R11) atx control only on own header
// (R12) held right key shows revision, 5s
// (R13) revision display also after restart
// (R14) right plus cancel at power restores defaults
// (R15) usb and serial hosts served together
// (R16) enabled interface blocks gpio on pins
// (R17) i2c ready low while buffer nonempty
// (R18) fixed pulse length, then hi-z
// (R19) pin roles change on clock edge
package hpm_pkg;
   localparam int unsigned NPINS = 13;
   localparam int unsigned NGPIO = 13;
   // gpio numbers on the shared header positions
   localparam int unsigned G_SRX = 7;
   localparam int unsigned G_STX = 8;
   localparam int unsigned G_SDA = 9;
   localparam int unsigned G_SCL = 10;
   localparam int unsigned G_ADC0 = 5;
   localparam int unsigned G_ADC1 = 6;
   localparam int unsigned G_MISO = 11;
   localparam int unsigned G_MOSI = 12;
   localparam int unsigned G_PCTL = 2;
   localparam int unsigned G_RCTL = 3;
   localparam int unsigned G_PSNS = 1;
   localparam int unsigned G_I2RDY = 4;
   // gpio mask reset: analog pins not digital, atx pins not user
   localparam logic [12:0] GPIO_EN_RST = 13'h1_F91;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned PULSE_MS = 200;
   localparam int unsigned HOLD_S = 5;
   // synchroniser depth: edges before a held key can reach the boot check
   localparam int unsigned SYNC_STAGES = 2;
   localparam longint unsigned PULSE_CYC = longint'(PULSE_MS) * CLK_MHZ * 1000;
   localparam longint unsigned HOLD_CYC = longint'(HOLD_S) * CLK_MHZ * 1000000;
   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_PWR = 3'b010,
      PS_RST = 3'b100
   } hpm_pulse_type;
   typedef enum logic [3:0] {
      BS_CHECK = 4'b0001,
      BS_SHOW = 4'b0010,
      BS_LINGER = 4'b0100,
      BS_DONE = 4'b1000
   } hpm_boot_type;
endpackage : hpm_pkg

// ==== core/hpm_sync.sv ====
`timescale 1ns/10ps
module hpm_sync #(
   parameter int unsigned W = 1
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_reg;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_reg <= '0;
         q_o <= '0;
      end else begin
         s1_reg <= d_i;
         q_o <= s1_reg;
      end
   end
endmodule : hpm_sync

// ==== verif/hpm_header_mux_asserts.sv ====
`timescale 1ns/10ps
module hpm_header_mux_asserts #(
   parameter logic [25:0] PULSE_LEN = 26'h8
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [12:0] pin_in_i,
   input wire logic [12:0] pin_out_o,
   input wire logic [12:0] pin_oe_o,
   input wire logic serial_en_i,
   input wire logic i2c_en_i,
   input wire logic spi_en_i,
   input wire logic atx_en_i,
   input wire logic power_invert_i,
   input wire logic restart_invert_i,
   input wire logic [12:0] gpio_en_i,
   input wire logic [12:0] gpio_dir_out_i,
   input wire logic [12:0] gpio_out_i,
   input wire logic [12:0] gpio_in_o,
   input wire logic [1:0] adc_in_o,
   input wire logic i2c_tx_pending_i,
   input wire logic spi_tx_pending_i,
   input wire logic power_req_i,
   input wire logic restart_req_i,
   input wire logic watchdog_req_i,
   input wire logic atx_busy_o
);
   logic [25:0] busy_cnt_reg;
   logic [1:0] up_reg;
   logic ok;
   // edges since reset release; outputs still show reset values at the first one
   assign ok = atx_en_i && !spi_en_i && !gpio_en_i[2] && !gpio_en_i[3];
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_cnt_reg <= '0;
         up_reg <= '0;
      end else begin
         busy_cnt_reg <= atx_busy_o ? busy_cnt_reg + 26'h1 : 26'h0;
         up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_pwr_take;
      power_req_i && !restart_req_i && !watchdog_req_i && !atx_busy_o && ok
         |=> atx_busy_o && pin_oe_o[9:8] == 2'h1 && pin_out_o[8] == $past(power_invert_i);
   endproperty
   a_pwr_take: assert property (p_pwr_take) else $error("power pulse not started");
   property p_rst_take;
      (restart_req_i || watchdog_req_i) && !atx_busy_o && ok
         |=> atx_busy_o && pin_oe_o[9:8] == 2'h2 && pin_out_o[9] == $past(restart_invert_i);
   endproperty
   a_rst_take: assert property (p_rst_take) else $error("restart pulse not started");
   property p_pulse_len;
      $fell(atx_busy_o) |-> busy_cnt_reg == PULSE_LEN;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
   property p_hiz_idle;
      ok && $past(ok) && !atx_busy_o |-> pin_oe_o[9:8] == 2'h0;
   endproperty
   a_hiz_idle: assert property (p_hiz_idle) else $error("atx pin driven while idle");
   property p_i2c_rdy;
      up_reg != 2'h0 && $past(i2c_en_i)
         |-> pin_oe_o[12] == $past(i2c_tx_pending_i) && !(pin_oe_o[12] && pin_out_o[12]);
   endproperty
   a_i2c_rdy: assert property (p_i2c_rdy) else $error("i2c ready pin wrong");
   property p_spi_rdy;
      up_reg != 2'h0 && $past(spi_en_i)
         |-> pin_oe_o[11] == $past(spi_tx_pending_i) && !(pin_oe_o[11] && pin_out_o[11]);
   endproperty
   a_spi_rdy: assert property (p_spi_rdy) else $error("spi ready pin wrong");
   property p_block;
      ($past(serial_en_i) |-> gpio_in_o[8:7] == 2'h0) and ($past(i2c_en_i) |-> gpio_in_o[10:9] == 2'h0);
   endproperty
   a_block: assert property (p_block) else $error("gpio seen on interface pin");
   property p_adc;
      up_reg == 2'h3 |-> adc_in_o == $past(pin_in_i[5:4], 3);
   endproperty
   a_adc: assert property (p_adc) else $error("analog pins not followed");
   property p_gpio_drive;
      up_reg != 2'h0 && $past(gpio_en_i[0] && gpio_dir_out_i[0])
         |-> pin_oe_o[10] && pin_out_o[10] == $past(gpio_out_i[0]);
   endproperty
   a_gpio_drive: assert property (p_gpio_drive) else $error("gpio0 not driven");
   c_pwr: cover property (pin_oe_o[8] && atx_busy_o);
   c_rst: cover property (pin_oe_o[9] && atx_busy_o);
   c_i2c: cover property (i2c_en_i && pin_oe_o[12]);
endmodule : hpm_header_mux_asserts
bind hpm_header_mux hpm_header_mux_asserts #(.PULSE_LEN(PULSE_LEN)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
   .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .serial_en_i(serial_en_i),
   .i2c_en_i(i2c_en_i), .spi_en_i(spi_en_i), .atx_en_i(atx_en_i), .power_invert_i(power_invert_i),
   .restart_invert_i(restart_invert_i), .gpio_en_i(gpio_en_i), .gpio_dir_out_i(gpio_dir_out_i),
   .gpio_out_i(gpio_out_i), .gpio_in_o(gpio_in_o), .adc_in_o(adc_in_o), .i2c_tx_pending_i(i2c_tx_pending_i),
   .spi_tx_pending_i(spi_tx_pending_i), .power_req_i(power_req_i), .restart_req_i(restart_req_i),
   .watchdog_req_i(watchdog_req_i), .atx_busy_o(atx_busy_o));

// ==== verif/hpm_host_model.sv ====
`timescale 1ns/10ps
module hpm_host_model (
   input wire logic mclk_i,
   input wire logic pwr_oe_i,
   input wire logic rst_oe_i,
   output logic sense_o,
   output logic [2:0] resets_o
);
   logic pwas, rwas;
   initial begin
      {sense_o, resets_o, pwas, rwas} = '0;
   end
   // power switch acts on release, like a real front-panel press; reset counts on press
   always @(posedge mclk_i) begin
      pwas <= pwr_oe_i;
      rwas <= rst_oe_i;
      if (pwas && !pwr_oe_i) sense_o <= !sense_o;
      if (rst_oe_i && !rwas) resets_o <= resets_o + 3'h1;
   end
endmodule : hpm_host_model

// ==== verif/tb.sv ====
`timescale 1ns/10ps
module tb;
   import hpm_pkg::*;
   localparam logic [25:0] PLEN = 26'h8;
   localparam logic [30:0] HLEN = 31'h14;
   logic [12:0] pin_in_i, pin_out_o, pin_oe_o, gpio_en_i, gpio_dir_out_i, gpio_out_i, gpio_in_o, ext;
   logic [1:0] adc_in_o;
   logic [2:0] resets;
   logic mclk_i, rst_i, serial_en_i, i2c_en_i, spi_en_i, atx_en_i, power_invert_i, restart_invert_i, ser_tx_i;
   logic ser_rx_o, i2c_sda_oe_i, i2c_sda_o, i2c_scl_o, i2c_tx_pending_i, spi_miso_i, spi_mosi_o, spi_cs_n_o;
   logic spi_sck_o, spi_tx_pending_i, power_req_i, restart_req_i, watchdog_req_i, host_power_on_o, atx_busy_o;
   logic key_right_i, key_cancel_i, usb_en_i, show_revision_o, restore_defaults_o, usb_active_o;
   logic serial_active_o, sense, pw;
   int errors = 0, n_compared = 0, cyc = 0;
   assign pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & (atx_en_i ? {ext[12], sense, ext[10:0]} : ext));
   hpm_header_mux #(.PULSE_LEN(PLEN), .HOLD_LEN(HLEN)) u_dut (.mclk_i, .rst_i, .pin_in_i, .pin_out_o,
      .pin_oe_o, .serial_en_i, .i2c_en_i, .spi_en_i, .atx_en_i, .power_invert_i, .restart_invert_i, .gpio_en_i,
      .gpio_dir_out_i, .gpio_out_i, .gpio_in_o, .adc_in_o, .ser_tx_i, .ser_rx_o, .i2c_sda_oe_i, .i2c_sda_o,
      .i2c_scl_o, .i2c_tx_pending_i, .spi_miso_i, .spi_mosi_o, .spi_cs_n_o, .spi_sck_o, .spi_tx_pending_i,
      .power_req_i, .restart_req_i, .watchdog_req_i, .host_power_on_o, .atx_busy_o, .key_right_i,
      .key_cancel_i, .usb_en_i, .show_revision_o, .restore_defaults_o, .usb_active_o, .serial_active_o);
   hpm_host_model u_host (.mclk_i(mclk_i), .pwr_oe_i(pin_oe_o[8]), .rst_oe_i(pin_oe_o[9]), .sense_o(sense),
      .resets_o(resets));
   always #2 mclk_i = ~mclk_i;
   task results();
      if (errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         results();
      end
   end
   task chk(string name, logic [12:0] exp, logic [12:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task tick(int n);
      repeat (n) @(posedge mclk_i);
   endtask : tick
   function automatic logic [1:0] exp_drv(logic en, logic dir, logic v);
      return (en && dir) ? {1'b1, v} : 2'h0;
   endfunction : exp_drv
   // interface inputs as the pins carry them; sda reads low while this side pulls it
   function automatic logic [5:0] exp_iface(logic [12:0] e, logic s, logic i, logic p, logic sda_low);
      return {e[0] & s, e[2] & !sda_low & i, e[3] & i, e[7] & p, e[8] | !p, e[9] & p};
   endfunction : exp_iface
   task boot(logic r, logic c);
      rst_i <= 1'b1;
      key_right_i <= r;
      key_cancel_i <= c;
      tick(2);
      rst_i <= 1'b0;
      tick(6);
      #1;
      chk("restore", c, restore_defaults_o);
      if (!c) chk("show", r, show_revision_o);
      key_right_i <= 1'b0;
      key_cancel_i <= 1'b0;
      tick(HLEN + 2);
      #1;
      if (!c) chk("show_hold", r, show_revision_o);
      tick(1);
      #1;
      chk("show_clr", 1'b0, show_revision_o);
   endtask : boot
   task pulse(int kind, logic inv);
      @(posedge mclk_i);
      power_invert_i <= inv;
      restart_invert_i <= inv;
      @(posedge mclk_i);
      {power_req_i, restart_req_i, watchdog_req_i} <= 3'(3'h4 >> kind);
      @(posedge mclk_i);
      {power_req_i, restart_req_i, watchdog_req_i} <= 3'h0;
      #1;
      chk("busy", 1'b1, atx_busy_o);
      chk("atx_oe", kind == 0 ? 2'h1 : 2'h2, pin_oe_o[9:8]);
      chk("atx_lvl", inv, kind == 0 ? pin_out_o[8] : pin_out_o[9]);
      @(posedge mclk_i);
      power_req_i <= 1'b1;
      @(posedge mclk_i);
      power_req_i <= 1'b0;
      tick(PLEN - 3);
      #1;
      chk("busy_end", 1'b1, atx_busy_o);
      tick(1);
      #1;
      chk("hiz", 3'h0, {atx_busy_o, pin_oe_o[9:8]});
      tick(6);
      #1;
      if (kind == 0) pw = !pw;
      chk("sense", pw, host_power_on_o);
   endtask : pulse
   initial begin
      {mclk_i, serial_en_i, i2c_en_i, spi_en_i, atx_en_i, power_invert_i, restart_invert_i, ser_tx_i} = '0;
      {i2c_sda_oe_i, i2c_tx_pending_i, spi_miso_i, spi_tx_pending_i, power_req_i, restart_req_i} = '0;
      {watchdog_req_i, key_right_i, key_cancel_i, usb_en_i, pw} = '0;
      {gpio_en_i, gpio_dir_out_i, gpio_out_i, ext} = '0;
      rst_i = 1'b1;
      void'($urandom(32'hc3d2_2497));
      boot(1'b1, 1'b0);
      boot(1'b1, 1'b0);
      boot(1'b0, 1'b0);
      boot(1'b1, 1'b1);
      boot(1'b0, 1'b0);
      atx_en_i <= 1'b1;
      gpio_en_i <= GPIO_EN_RST;
      for (int k = 0; k < 6; k++) pulse(k % 3, k >= 3);
      chk("resets", 3'h4, resets);
      atx_en_i <= 1'b0;
      repeat (150) begin
         @(posedge mclk_i);
         {serial_en_i, i2c_en_i, spi_en_i, usb_en_i, i2c_tx_pending_i, spi_tx_pending_i} <= 6'($urandom);
         {ser_tx_i, spi_miso_i, i2c_sda_oe_i} <= 3'($urandom);
         // analog pins kept off gpio so they stay undriven
         gpio_en_i <= 13'($urandom) & 13'h1_F9F;
         gpio_dir_out_i <= 13'($urandom);
         gpio_out_i <= 13'($urandom);
         ext <= 13'($urandom);
         tick(4);
         #1;
         // level means nothing while the pin is released
         chk("gpio0", exp_drv(gpio_en_i[0], gpio_dir_out_i[0], gpio_out_i[0]),
             {pin_oe_o[10], pin_oe_o[10] & pin_out_o[10]});
         chk("iface_in", exp_iface(ext, serial_en_i, i2c_en_i, spi_en_i, i2c_sda_oe_i),
             {ser_rx_o, i2c_sda_o, i2c_scl_o, spi_mosi_o, spi_cs_n_o, spi_sck_o});
         if (!gpio_dir_out_i[0]) chk("gpio0_in", gpio_en_i[0] & ext[10], gpio_in_o[0]);
         chk("adc", ext[5:4], adc_in_o);
         chk("active", {usb_en_i, serial_en_i}, {usb_active_o, serial_active_o});
         if (i2c_en_i) chk("i2c_rdy", i2c_tx_pending_i, pin_oe_o[12] & ~pin_out_o[12]);
         if (spi_en_i) chk("spi_rdy", spi_tx_pending_i, pin_oe_o[11] & ~pin_out_o[11]);
         if (serial_en_i) chk("ser_blk", 2'h0, gpio_in_o[8:7]);
      end
      results();
   end
endmodule : tb
